// ==== rtl/mpc_pkg.sv ====
package mpc_pkg;
	// register indices of the configuration words
	localparam logic [6:0] MPC_OFS_STARTUP = 7'h0D;
	localparam logic [6:0] MPC_OFS_FEEDBACK = 7'h0E;
	localparam logic [6:0] MPC_OFS_BRAKE = 7'h0F;
	localparam logic [6:0] MPC_OFS_LOCK = 7'h10;
	localparam logic [6:0] MPC_OFS_SPEED = 7'h11;
	localparam logic [6:0] MPC_SHADOW_BASE = 7'h40;
	// field positions
	localparam int MPC_DELAY_BIT = 14;
	localparam int MPC_FBOFF_BIT = 4;
	localparam int MPC_BRK_LO = 14;
	localparam int MPC_DT_LO = 8;
	localparam int MPC_SOFTON_BIT = 7;
	localparam int MPC_SOFTOFF_BIT = 6;
	localparam int MPC_ANG_LO = 2;
	localparam int MPC_BEMF_LO = 12;
	localparam int MPC_FALL_LO = 10;
	localparam int MPC_RISE_LO = 8;
	localparam int MPC_ALIGN_LO = 6;
	localparam int MPC_BLANK_LO = 4;
	localparam int MPC_RESTART_BIT = 3;
	localparam int MPC_OCSEL_LO = 0;
	localparam int MPC_SERIAL_BIT = 9;
	// reset values of the shadow words
	localparam logic [16:0] MPC_RST_WORD = 17'h00000;
	// timing
	localparam longint MPC_CLK_HZ = 125000000;
	localparam int MPC_CLK_NS = 8;
	localparam int MPC_DELAY_SHORT_MS = 25;
	localparam int MPC_DELAY_LONG_MS = 100;
	localparam int MPC_DT_ZERO_NS = 640;
	localparam int MPC_DT_STEP_NS = 40;
	localparam int MPC_BLANK_STEP_NS = 320;
	localparam int MPC_FILT_STEP_NS = 120;
	localparam int MPC_RESTART_S = 5;
	localparam longint MPC_DELAY_SHORT_CYC = MPC_CLK_HZ * MPC_DELAY_SHORT_MS / 1000;
	localparam longint MPC_DELAY_LONG_CYC = MPC_CLK_HZ * MPC_DELAY_LONG_MS / 1000;
	localparam longint MPC_RESTART_CYC = MPC_CLK_HZ * MPC_RESTART_S;
	localparam int MPC_DT_STEP_CYC = MPC_DT_STEP_NS / MPC_CLK_NS;
	localparam int MPC_BLANK_STEP_CYC = MPC_BLANK_STEP_NS / MPC_CLK_NS;
	localparam int MPC_FILT_STEP_CYC = MPC_FILT_STEP_NS / MPC_CLK_NS;
	localparam int MPC_DT_ZERO_CYC = MPC_DT_ZERO_NS / MPC_CLK_NS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [16:0] wdata;
	} mpc_reg_req_t;

	typedef struct packed {
		logic delay_long;
		logic feedback_terminal_off;
		logic [2:0] brake_permit_current_level;
		logic [3:0] deadtime_code;
		logic soft_start;
		logic soft_stop;
		logic [1:0] startup_angle_stall_sel;
		logic [1:0] backemf_stall_filter;
		logic [1:0] falling_slew_limit;
		logic [1:0] rising_slew_limit;
		logic [1:0] align_sel;
		logic [1:0] overcurrent_blank_sel;
		logic overcurrent_restart_sel;
		logic [2:0] overcurrent_filter_side_sel;
		logic serial_cmd;
		logic [8:0] speed_request;
	} mpc_cfg_t;

	typedef struct packed {
		logic upper_on;
		logic lower_on;
		logic [7:0] filt_cyc;
	} mpc_oc_t;
endpackage

// ==== rtl/mpc_cfg_bank.sv ====
`timescale 1ns/100ps
module mpc_cfg_bank #(
	parameter longint DELAY_SHORT_CYC = mpc_pkg::MPC_DELAY_SHORT_CYC,
	parameter longint DELAY_LONG_CYC = mpc_pkg::MPC_DELAY_LONG_CYC,
	parameter longint RESTART_CYC = mpc_pkg::MPC_RESTART_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire mpc_pkg::mpc_reg_req_t req_i,
	input wire logic [10:0] rated_current_i,
	input wire logic align_go_mode_i,
	input wire logic start_cmd_i,
	input wire logic restart_req_i,
	input wire logic switch_edge_i,
	input wire logic oc_upper_i,
	input wire logic oc_lower_i,
	input wire logic brake_req_i,
	input wire logic brake_always_i,
	input wire logic [10:0] motor_current_i,
	input wire logic [8:0] terminal_speed_i,
	input wire logic feedback_pulse_i,
	output logic [16:0] rdata_o,
	output mpc_pkg::mpc_cfg_t cfg_o,
	output logic speed_feedback_output_o,
	output logic settle_window_o,
	output logic [7:0] deadtime_cyc_o,
	output logic [10:0] brake_permit_current_level_o,
	output logic brake_o,
	output logic overcurrent_fault_o,
	output logic drive_enable_o,
	output logic [8:0] speed_cmd_o
);
	import mpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [4:0][16:0] word;
		logic serial_written;
		logic [16:0] rdata;
		mpc_cfg_t cfg;
		logic fb;
		logic [31:0] settle_cnt;
		logic settle;
		logic [7:0] dt;
		logic [10:0] thr;
		logic brake;
		logic [7:0] blank_cnt;
		logic [7:0] filt_cnt;
		logic fault;
		logic [31:0] restart_cnt;
		logic [8:0] spd;
		logic drv_en;
	} mpc_state_t;

	mpc_state_t s_q, s_d;
	mpc_cfg_t c;
	mpc_oc_t oc;
	logic [2:0] widx;
	logic hit;
	logic oc_live;
	logic oc_trip;
	logic [7:0] blank_len;

	// decode of filter time and side enables
	function automatic mpc_oc_t oc_decode(input logic [2:0] code);
		mpc_oc_t r;
		r.upper_on = (code != 3'h5) && (code != 3'h7);
		r.lower_on = (code != 3'h6) && (code != 3'h7);
		r.filt_cyc = (code > 3'h4) ? 8'(4 * MPC_FILT_STEP_CYC) : 8'(code * MPC_FILT_STEP_CYC);
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		// every field straight from the shadow words
		c.delay_long = s_q.word[0][MPC_DELAY_BIT];
		c.feedback_terminal_off = s_q.word[1][MPC_FBOFF_BIT];
		c.brake_permit_current_level = s_q.word[2][MPC_BRK_LO+:3];
		c.deadtime_code = s_q.word[2][MPC_DT_LO+:4];
		c.soft_start = s_q.word[2][MPC_SOFTON_BIT];
		c.soft_stop = s_q.word[2][MPC_SOFTOFF_BIT];
		c.startup_angle_stall_sel = s_q.word[2][MPC_ANG_LO+:2];
		c.backemf_stall_filter = s_q.word[3][MPC_BEMF_LO+:2];
		c.falling_slew_limit = s_q.word[3][MPC_FALL_LO+:2];
		c.rising_slew_limit = s_q.word[3][MPC_RISE_LO+:2];
		c.align_sel = s_q.word[3][MPC_ALIGN_LO+:2];
		c.overcurrent_blank_sel = s_q.word[3][MPC_BLANK_LO+:2];
		c.overcurrent_restart_sel = s_q.word[3][MPC_RESTART_BIT];
		c.overcurrent_filter_side_sel = s_q.word[3][MPC_OCSEL_LO+:3];
		c.serial_cmd = s_q.word[4][MPC_SERIAL_BIT];
		c.speed_request = s_q.word[4][8:0];
		oc = oc_decode(c.overcurrent_filter_side_sel);
		oc_live = (oc.upper_on && oc_upper_i) || (oc.lower_on && oc_lower_i);
		// trip once blanking is over and the condition outlasted the filter time
		oc_trip = !switch_edge_i && (s_q.blank_cnt == 8'h00) && oc_live && (s_q.filt_cnt >= oc.filt_cyc);
		blank_len = (c.overcurrent_blank_sel == 2'h0) ? 8'h00 :
			8'(MPC_BLANK_STEP_CYC << (c.overcurrent_blank_sel - 2'h1));
		// words answer at the eeprom index and at the shadow index
		widx = 3'h0;
		hit = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (req_i.addr == 7'(MPC_OFS_STARTUP + i) || req_i.addr == 7'(MPC_SHADOW_BASE + MPC_OFS_STARTUP + i)) begin
				widx = 3'(i);
				hit = 1'b1;
			end
		end

		s_d = s_q;
		s_d.cfg = c;
		if (req_i.wr && hit) begin
			s_d.word[widx] = req_i.wdata;
			s_d.serial_written = 1'b1;
		end
		s_d.rdata = (req_i.rd && hit) ? s_q.word[widx] : 17'h00000;
		// terminal drops after the first write or when turned off
		s_d.fb = !c.feedback_terminal_off && !s_q.serial_written && feedback_pulse_i;
		if (start_cmd_i && !align_go_mode_i) begin
			s_d.settle_cnt = c.delay_long ? 32'(DELAY_LONG_CYC) : 32'(DELAY_SHORT_CYC);
			s_d.settle = 1'b1;
		end else if (s_q.settle_cnt != 32'h00000000) begin
			s_d.settle_cnt = s_q.settle_cnt - 32'h00000001;
			s_d.settle = (s_q.settle_cnt != 32'h00000001);
		end else begin
			s_d.settle = 1'b0;
		end
		s_d.dt = (c.deadtime_code == 4'h0) ? 8'(MPC_DT_ZERO_CYC) :
			8'((c.deadtime_code + 8'h01) * MPC_DT_STEP_CYC);
		s_d.thr = rated_current_i >> c.brake_permit_current_level;
		// conditional brake waits for the threshold
		s_d.brake = brake_req_i && (brake_always_i || (motor_current_i < s_q.thr));
		// restart on request or after the timed wait
		if (s_q.fault) begin
			if (!c.overcurrent_restart_sel) begin
				if (restart_req_i) begin
					s_d.fault = 1'b0;
				end
			end else if (s_q.restart_cnt >= 32'(RESTART_CYC - 1)) begin
				s_d.fault = 1'b0;
				s_d.restart_cnt = 32'h00000000;
			end else begin
				s_d.restart_cnt = s_q.restart_cnt + 32'h00000001;
			end
		end else begin
			s_d.restart_cnt = 32'h00000000;
		end
		// blanking, persistence filter
		// placed after the restart so a trip in the same cycle wins over the clear
		if (switch_edge_i) begin
			s_d.blank_cnt = blank_len;
			s_d.filt_cnt = 8'h00;
		end else if (s_q.blank_cnt != 8'h00) begin
			s_d.blank_cnt = s_q.blank_cnt - 8'h01;
		end else if (oc_live) begin
			if (oc_trip) begin
				s_d.fault = 1'b1;
			end else begin
				s_d.filt_cnt = s_q.filt_cnt + 8'h01;
			end
		end else begin
			s_d.filt_cnt = 8'h00;
		end
		// registered so the enable pin comes straight from a flop
		s_d.drv_en = !s_d.fault;
		// register speed only in serial mode
		s_d.spd = c.serial_cmd ? c.speed_request : terminal_speed_i;
	end

	////////////////////////////////////////////////////////////////////////
	// reset words are all zero; no eeprom load model here
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			s_q <= '0;
			s_q.drv_en <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign cfg_o = s_q.cfg;
	assign speed_feedback_output_o = s_q.fb;
	assign settle_window_o = s_q.settle;
	assign deadtime_cyc_o = s_q.dt;
	assign brake_permit_current_level_o = s_q.thr;
	assign brake_o = s_q.brake;
	assign overcurrent_fault_o = s_q.fault;
	assign drive_enable_o = s_q.drv_en;
	assign speed_cmd_o = s_q.spd;

	////////////////////////////////////////////////////////////////////////
	chk_speed_source: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$past(c.serial_cmd) |-> speed_cmd_o == $past(c.speed_request)) else $error("speed source wrong");
	chk_feedback_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$past(s_q.serial_written) |-> !speed_feedback_output_o) else $error("feedback after write");
	chk_deadtime_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) && $past(c.deadtime_code) == 4'h0 |-> deadtime_cyc_o == 8'h50) else $error("deadtime zero code");
	chk_deadtime_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) && $past(c.deadtime_code) != 4'h0 |-> deadtime_cyc_o == 8'(($past(c.deadtime_code) + 8'h01) * 5))
		else $error("deadtime step code");
	chk_brake_wait: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		brake_o && !$past(brake_always_i) |-> $past(motor_current_i) < $past(s_q.thr)) else $error("unsafe brake");
	chk_thr_shift: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		c.brake_permit_current_level == 3'h7 |=> brake_permit_current_level_o == ($past(rated_current_i) >> 7))
		else $error("threshold wrong");
	chk_blank_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		switch_edge_i && blank_len != 8'h00 && !overcurrent_fault_o |=> !overcurrent_fault_o) else $error("fault in blank");
	chk_settle_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		start_cmd_i && !align_go_mode_i |=> settle_window_o [*2]) else $error("settle window missing");
	chk_restart_req: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		overcurrent_fault_o && !c.overcurrent_restart_sel && restart_req_i && !oc_trip |=> !overcurrent_fault_o)
		else $error("restart ignored");
	chk_side_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		c.overcurrent_filter_side_sel == 3'h7 && !overcurrent_fault_o |=> !overcurrent_fault_o)
		else $error("fault while disabled");

	////////////////////////////////////////////////////////////////////////
	// register access and decode
	chk_rdata_miss: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.rd && !hit |=> rdata_o == 17'h00000)
		else $error("read of unmapped index not zero");
	chk_rdata_hit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.rd && hit |=> rdata_o == $past(s_q.word[widx]))
		else $error("read data wrong");
	chk_word_store: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		req_i.wr && hit |=> s_q.word[$past(widx)] == $past(req_i.wdata))
		else $error("write not stored");
	chk_fb_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		$past(c.feedback_terminal_off) |-> !speed_feedback_output_o)
		else $error("feedback while turned off");
	chk_soft_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o.soft_start == $past(s_q.word[2][MPC_SOFTON_BIT]))
		else $error("soft start decode");
	chk_soft_stop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o.soft_stop == $past(s_q.word[2][MPC_SOFTOFF_BIT]))
		else $error("soft stop decode");
	chk_angle_lock: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o.startup_angle_stall_sel == $past(s_q.word[2][3:2]))
		else $error("angle lock decode");
	chk_backemf_filter: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o.backemf_stall_filter == $past(s_q.word[3][13:12]))
		else $error("back-emf filter decode");
	chk_slew_limits: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> {cfg_o.falling_slew_limit, cfg_o.rising_slew_limit} == $past(s_q.word[3][11:8]))
		else $error("slew limit decode");
	chk_align_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o.align_sel == $past(s_q.word[3][7:6]))
		else $error("align code decode");
	chk_cfg_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) |-> cfg_o == $past(c))
		else $error("config not from shadow words");

	////////////////////////////////////////////////////////////////////////
	// startup, brake and speed command
	chk_settle_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		start_cmd_i && align_go_mode_i && !settle_window_o |=> !settle_window_o)
		else $error("settle window in align-and-go");
	chk_thr_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		c.brake_permit_current_level == 3'h0 |=> brake_permit_current_level_o == $past(rated_current_i))
		else $error("full threshold wrong");
	chk_brake_always: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		brake_req_i && brake_always_i |=> brake_o)
		else $error("immediate brake missing");
	chk_speed_terminal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!$past(reset_i) && !$past(c.serial_cmd) |-> speed_cmd_o == $past(terminal_speed_i))
		else $error("register speed used outside serial mode");

	////////////////////////////////////////////////////////////////////////
	// overcurrent path
	chk_blank_len: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		switch_edge_i |=> s_q.blank_cnt == $past(blank_len))
		else $error("blank length wrong");
	chk_blank_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		s_q.blank_cnt != 8'h00 && !switch_edge_i |=> s_q.blank_cnt == $past(s_q.blank_cnt) - 8'h01)
		else $error("blank count wrong");
	chk_filter_wait: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!overcurrent_fault_o && !oc_trip |=> !overcurrent_fault_o)
		else $error("fault before filter time");
	chk_filter_trip: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		oc_trip |=> overcurrent_fault_o)
		else $error("fault missing after filter time");
	chk_side_upper: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		c.overcurrent_filter_side_sel == 3'h5 && !oc_lower_i && !overcurrent_fault_o |=> !overcurrent_fault_o)
		else $error("upper side not disabled");
	chk_side_lower: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		c.overcurrent_filter_side_sel == 3'h6 && !oc_upper_i && !overcurrent_fault_o |=> !overcurrent_fault_o)
		else $error("lower side not disabled");
	chk_restart_wait: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		overcurrent_fault_o && !c.overcurrent_restart_sel && !restart_req_i |=> overcurrent_fault_o)
		else $error("fault cleared without request");
	chk_restart_timed: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		overcurrent_fault_o && c.overcurrent_restart_sel && s_q.restart_cnt < 32'(RESTART_CYC - 1) |=> overcurrent_fault_o)
		else $error("timed restart too early");
	chk_drive_enable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		drive_enable_o == !overcurrent_fault_o)
		else $error("drive enable disagrees with fault");
endmodule

// ==== sim/mpc_host.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module mpc_host (
	input wire logic clk_sys_i,
	input wire logic [16:0] rdata_i,
	output mpc_pkg::mpc_reg_req_t req_o
);
	import mpc_pkg::*;
	initial req_o = '0;
	// one idle cycle between accesses; a released bus shows the inverse, never the old value
	task automatic wr(input logic [6:0] a, input logic [16:0] d);
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [6:0] a, output logic [16:0] d);
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 17'h00000};
		@(posedge clk_sys_i);
		#1 d = rdata_i;
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 17'h1FFFF};
	endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module testbench;
	import mpc_pkg::*;
	logic clk_sys_i, reset_i, align_go, start, restart, edge_p, oc_hi, oc_lo, brk_req, brk_now, fb;
	logic [10:0] rated, cur, lvl;
	logic [8:0] term, spd;
	logic [16:0] rdata, d;
	logic [7:0] dt;
	logic fb_o, settle, brake, fault, drv_en;
	mpc_reg_req_t req;
	mpc_cfg_t cfg;
	int error_cnt, num_checks, n;
	mpc_host mpc_host_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
	// short counts keep the run small
	mpc_cfg_bank #(.DELAY_SHORT_CYC(20), .DELAY_LONG_CYC(40), .RESTART_CYC(50)) mpc_cfg_bank_i (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req), .rated_current_i(rated),
		.align_go_mode_i(align_go), .start_cmd_i(start), .restart_req_i(restart), .switch_edge_i(edge_p),
		.oc_upper_i(oc_hi), .oc_lower_i(oc_lo), .brake_req_i(brk_req), .brake_always_i(brk_now),
		.motor_current_i(cur), .terminal_speed_i(term), .feedback_pulse_i(fb), .rdata_o(rdata),
		.cfg_o(cfg), .speed_feedback_output_o(fb_o), .settle_window_o(settle), .deadtime_cyc_o(dt),
		.brake_permit_current_level_o(lvl), .brake_o(brake), .overcurrent_fault_o(fault),
		.drive_enable_o(drv_en), .speed_cmd_o(spd));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rng(input int k, input int lo, input int hi);
		num_checks++;
		if (k < lo || k > hi) begin
			error_cnt++;
			$display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, k, lo, hi);
		end
	endtask
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic edges(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	// decoded outputs follow one edge after the write is taken
	task automatic wcfg(input logic [6:0] a, input logic [16:0] v);
		mpc_host_i.wr(a, v);
		edges(2);
	endtask
	task automatic cnt(ref logic s, input logic v, output int k);
		k = 0;
		while (s === v && k < 1000) begin
			edges(1);
			k++;
		end
	endtask
	task automatic pulse(ref logic s);
		edges(1);
		s = 1'b1;
		edges(1);
		s = 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#300000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{align_go, start, restart, edge_p, oc_hi, oc_lo, brk_req, brk_now} = '0;
		reset_i = 1'b1;
		fb = 1'b1;
		rated = 11'h400;
		cur = 11'h7FF;
		term = 9'h0AB;
		edges(10);
		reset_i = 1'b0;
		edges(3);
		chk(drv_en, 1'b1);
		chk(fb_o, 1'b1);
		fb = 1'b0;
		edges(2);
		chk(fb_o, 1'b0);
		fb = 1'b1;
		edges(2);
		chk(fb_o, 1'b1);
		chk(spd, term);
		for (int i = 0; i < 5; i++) begin
			mpc_host_i.rd(MPC_OFS_STARTUP + 7'(i), d);
			chk(d, MPC_RST_WORD);
		end
		for (int i = 0; i < 5; i++) begin
			mpc_host_i.wr(MPC_OFS_STARTUP + 7'(i), 17'h1A5A0 ^ 17'(i));
			mpc_host_i.rd(MPC_SHADOW_BASE + MPC_OFS_STARTUP + 7'(i), d);
			chk(d, 17'h1A5A0 ^ 17'(i));
		end
		mpc_host_i.rd(7'h12, d);
		chk(d, 17'h00000);
		chk(fb_o, 1'b0);
		for (int c = 0; c < 16; c++) begin
			wcfg(MPC_OFS_BRAKE, 17'(c << 8));
			chk(dt, (c == 0) ? 17'h00050 : 17'((c + 1) * 5));
		end
		for (int k = 0; k < 8; k++) begin
			wcfg(MPC_OFS_BRAKE, 17'(k << 14));
			chk(lvl, 17'(rated >> k));
		end
		// threshold now rated/128; current above it blocks a conditional brake
		brk_req = 1'b1;
		edges(3);
		chk(brake, 1'b0);
		cur = 11'h007;
		edges(3);
		chk(brake, 1'b1);
		cur = 11'h7FF;
		brk_now = 1'b1;
		edges(3);
		chk(brake, 1'b1);
		brk_req = 1'b0;
		wcfg(MPC_OFS_BRAKE, 17'h000C4);
		chk(17'({cfg.soft_start, cfg.soft_stop, cfg.startup_angle_stall_sel}), 17'h0000D);
		wcfg(MPC_OFS_LOCK, 17'h02DF6);
		chk(17'({cfg.backemf_stall_filter, cfg.falling_slew_limit, cfg.rising_slew_limit, cfg.align_sel,
			cfg.overcurrent_blank_sel, cfg.overcurrent_restart_sel, cfg.overcurrent_filter_side_sel}), 17'h02DF6);
		wcfg(MPC_OFS_SPEED, 17'h003FF);
		chk(spd, 9'h1FF);
		wcfg(MPC_OFS_SPEED, 17'h001FF);
		chk(spd, term);
		wcfg(MPC_OFS_STARTUP, 17'h00000);
		pulse(start);
		cnt(settle, 1'b1, n);
		rng(n, 19, 21);
		wcfg(MPC_OFS_STARTUP, 17'h04000);
		pulse(start);
		cnt(settle, 1'b1, n);
		rng(n, 39, 41);
		align_go = 1'b1;
		pulse(start);
		chk(settle, 1'b0);
		// filter 120 ns is 15 cycles of persistence before the trip
		wcfg(MPC_OFS_LOCK, 17'h00001);
		oc_hi = 1'b1;
		cnt(fault, 1'b0, n);
		rng(n, 14, 18);
		oc_hi = 1'b0;
		chk(drv_en, 1'b0);
		pulse(restart);
		edges(2);
		chk(fault, 1'b0);
		wcfg(MPC_OFS_LOCK, 17'h00031);
		oc_lo = 1'b1;
		pulse(edge_p);
		cnt(fault, 1'b0, n);
		rng(n, 170, 180);
		oc_lo = 1'b0;
		pulse(restart);
		wcfg(MPC_OFS_LOCK, 17'h00007);
		{oc_hi, oc_lo} = 2'b11;
		edges(100);
		chk(fault, 1'b0);
		oc_lo = 1'b0;
		wcfg(MPC_OFS_LOCK, 17'h00005);
		edges(100);
		chk(fault, 1'b0);
		wcfg(MPC_OFS_LOCK, 17'h0000E);
		cnt(fault, 1'b0, n);
		rng(n, 55, 66);
		oc_hi = 1'b0;
		cnt(fault, 1'b1, n);
		rng(n, 45, 53);
		stop_test();
	end
endmodule
